// >>> wtc_regs.svh
// constants of the wide threshold comparator: reset values and timing
// assumes a core clock of 50 MHz; included by bare name
`ifndef WTC_REGS_SVH
`define WTC_REGS_SVH

`define WTC_CLK_PERIOD_NS      20
`define WTC_SCAN_TIME_NS       1000
`define WTC_SCAN_CYCLES        ((`WTC_SCAN_TIME_NS + `WTC_CLK_PERIOD_NS - 1) / `WTC_CLK_PERIOD_NS)
`define WTC_SCAN_CNT_W         6

`define WTC_LOWER_SETTING_RST  32'h0000_0000
`define WTC_UPPER_SETTING_RST  32'h0000_0000
`define WTC_RESULT_RST         1'b0

`define WTC_SETTING_SEL_LOWER  1'b0
`define WTC_SETTING_SEL_UPPER  1'b1

`define WTC_FLOAT_SIGN_BIT     31
`define WTC_FLOAT_EXP_MSB      30
`define WTC_FLOAT_EXP_LSB      23
`define WTC_FLOAT_MANT_MSB     22
`define WTC_FLOAT_EXP_ALL_ONES 8'hff

`endif

// >>> wtc_pkg.sv
// types shared by the wide threshold comparator files
// assumes nothing of its surroundings
package wtc_pkg;

    typedef enum logic [2:0] {
        WTC_MODE_EQ  = 3'h0,
        WTC_MODE_GT  = 3'h1,
        WTC_MODE_LT  = 3'h2,
        WTC_MODE_GE  = 3'h3,
        WTC_MODE_LE  = 3'h4,
        WTC_MODE_NE  = 3'h5,
        WTC_MODE_IN  = 3'h6,
        WTC_MODE_OUT = 3'h7
    } wtc_mode_t;

    typedef enum logic {
        WTC_FMT_INT   = 1'b0,
        WTC_FMT_FLOAT = 1'b1
    } wtc_format_t;

    typedef enum logic [1:0] {
        WTC_ST_IDLE    = 2'b00,
        WTC_ST_LATCH   = 2'b01,
        WTC_ST_DECIDE  = 2'b11,
        WTC_ST_PUBLISH = 2'b10
    } wtc_state_t;

endpackage

// >>> wtc_scan_tick.sv
// scan rate divider: one-cycle tick once per scan period
// assumes a single core clock and asynchronous active-low reset
`timescale 1ns/1ns
`include "wtc_regs.svh"

module wtc_scan_tick (
    input  wire logic core_clk,
    input  wire logic nrst,
    output logic      scan_tick
);
    import wtc_pkg::*;

    localparam logic [`WTC_SCAN_CNT_W-1:0] SCAN_LAST =
        `WTC_SCAN_CNT_W'(`WTC_SCAN_CYCLES - 1);

    logic [`WTC_SCAN_CNT_W-1:0] cnt_r;
    logic [`WTC_SCAN_CNT_W-1:0] cnt_nxt;
    logic                       tick_r;
    logic                       tick_nxt;

    always_comb begin
        tick_nxt = (cnt_r == SCAN_LAST);
        cnt_nxt  = tick_nxt ? '0 : cnt_r + `WTC_SCAN_CNT_W'(1);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign scan_tick = tick_r;

endmodule

// >>> wtc_order.sv
// orders two 32-bit words as single-precision floats or signed integers
// assumes stable inputs; purely combinational
`timescale 1ns/1ns
`include "wtc_regs.svh"

module wtc_order (
    input  wire logic               [31:0] val_x,
    input  wire logic               [31:0] val_y,
    input  wire wtc_pkg::wtc_format_t      format_sel,
    output logic                           x_less,
    output logic                           x_equal,
    output logic                           unordered
);
    import wtc_pkg::*;

    function automatic logic is_nan(input logic [31:0] v);
        is_nan = (v[`WTC_FLOAT_EXP_MSB:`WTC_FLOAT_EXP_LSB] == `WTC_FLOAT_EXP_ALL_ONES)
                 && (v[`WTC_FLOAT_MANT_MSB:0] != '0);
    endfunction

    // sign-magnitude to monotonic unsigned key
    function automatic logic [31:0] fkey(input logic [31:0] v);
        fkey = v[`WTC_FLOAT_SIGN_BIT] ? ~v : (v | 32'h8000_0000);
    endfunction

    logic both_zero;

    always_comb begin
        both_zero = (val_x[30:0] == '0) && (val_y[30:0] == '0);
        unordered = 1'b0;
        x_less    = 1'b0;
        x_equal   = 1'b0;
        if (format_sel == WTC_FMT_FLOAT) begin
            unordered = is_nan(val_x) || is_nan(val_y);
            if (!unordered) begin
                // plus and minus zero are the same number
                x_equal = both_zero || (val_x == val_y);
                x_less  = !x_equal && (fkey(val_x) < fkey(val_y));
            end
        end else begin
            x_equal = (val_x == val_y);
            x_less  = $signed(val_x) < $signed(val_y);
        end
    end

endmodule

// >>> wtc_top.sv
// wide threshold comparator: operand against lower and upper thresholds
// assumes operands and controls come from logic on core_clk; no sync needed
`timescale 1ns/1ns
`include "wtc_regs.svh"

// Summary of operation
// - In float format the operand and thresholds are compared as 32-bit floats.
// - In integer format they are compared as 32-bit signed two's-complement values.
// - A result is produced only while compare_enable is held high by the driver.
// - While enabled the result is high when the chosen condition holds, else low.
// - Each threshold comes from its stored setting or from its port when connected.
// - Equal mode sets the result when operand_a equals lower_threshold.
// - Greater mode sets it only when operand_a is strictly above lower_threshold.
// - Smaller mode sets it only when operand_a is strictly below lower_threshold.
// - Greater-or-equal mode sets it when operand_a is at or above lower_threshold.
// - Smaller-or-equal mode sets it when operand_a is at or below lower_threshold.
// - Not-equal mode sets it whenever operand_a differs from lower_threshold.
// - In-range mode sets it when operand_a lies strictly between both thresholds.
// - Out-of-range mode sets it when operand_a is above upper or below lower.
// - Single-threshold modes ignore upper_threshold; only window modes use both.
// - While compare_enable is low the result holds its last value, high or low.
module wtc_top (
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire wtc_pkg::wtc_format_t  format_sel,
    input  wire wtc_pkg::wtc_mode_t    compare_mode,
    input  wire logic                  compare_enable,
    input  wire logic           [31:0] operand_a,
    input  wire logic           [31:0] lower_threshold,
    input  wire logic           [31:0] upper_threshold,
    input  wire logic                  lower_port_connected,
    input  wire logic                  upper_port_connected,
    input  wire logic                  setting_wr,
    input  wire logic                  setting_sel,
    input  wire logic           [31:0] setting_data,
    output logic                       compare_result,
    output logic                       float_compare_result,
    output logic                       signed_compare_result,
    output logic                       result_update,
    output logic                       unordered_seen,
    output logic                [31:0] lower_threshold_setting,
    output logic                [31:0] upper_threshold_setting
);
    import wtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // mode decoding

    function automatic logic uses_upper(input wtc_mode_t m);
        uses_upper = (m == WTC_MODE_IN) || (m == WTC_MODE_OUT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // stored threshold settings

    logic [31:0] lower_set_r;
    logic [31:0] lower_set_nxt;
    logic [31:0] upper_set_r;
    logic [31:0] upper_set_nxt;

    always_comb begin
        lower_set_nxt = lower_set_r;
        upper_set_nxt = upper_set_r;
        if (setting_wr) begin
            if (setting_sel == `WTC_SETTING_SEL_LOWER) begin
                lower_set_nxt = setting_data;
            end else begin
                upper_set_nxt = setting_data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lower_set_r <= `WTC_LOWER_SETTING_RST;
            upper_set_r <= `WTC_UPPER_SETTING_RST;
        end else begin
            lower_set_r <= lower_set_nxt;
            upper_set_r <= upper_set_nxt;
        end
    end

    assign lower_threshold_setting = lower_set_r;
    assign upper_threshold_setting = upper_set_r;

    ////////////////////////////////////////////////////////////////////////
    // scan tick

    logic scan_tick;

    wtc_scan_tick u_scan (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .scan_tick (scan_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // evaluation sequencer and operand snapshot
    // snapshot keeps one scan's operands coherent across the pipeline

    wtc_state_t  state_r;
    wtc_state_t  state_nxt;
    logic [31:0] op_a_r;
    logic [31:0] op_a_nxt;
    logic [31:0] lo_r;
    logic [31:0] lo_nxt;
    logic [31:0] hi_r;
    logic [31:0] hi_nxt;
    wtc_mode_t   mode_r;
    wtc_mode_t   mode_nxt;
    wtc_format_t fmt_r;
    wtc_format_t fmt_nxt;

    always_comb begin
        state_nxt = state_r;
        op_a_nxt  = op_a_r;
        lo_nxt    = lo_r;
        hi_nxt    = hi_r;
        mode_nxt  = mode_r;
        fmt_nxt   = fmt_r;
        unique case (state_r)
            WTC_ST_IDLE: begin
                if (scan_tick && compare_enable) begin
                    state_nxt = WTC_ST_LATCH;
                end
            end
            WTC_ST_LATCH: begin
                op_a_nxt = operand_a;
                mode_nxt = compare_mode;
                fmt_nxt  = format_sel;
                lo_nxt   = lower_port_connected ? lower_threshold : lower_set_r;
                // upper word kept out of single-threshold modes
                hi_nxt   = !uses_upper(compare_mode) ? lo_r :
                           upper_port_connected ? upper_threshold : upper_set_r;
                state_nxt = WTC_ST_DECIDE;
            end
            WTC_ST_DECIDE: begin
                state_nxt = WTC_ST_PUBLISH;
            end
            WTC_ST_PUBLISH: begin
                state_nxt = WTC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= WTC_ST_IDLE;
            op_a_r  <= '0;
            lo_r    <= '0;
            hi_r    <= '0;
            mode_r  <= WTC_MODE_EQ;
            fmt_r   <= WTC_FMT_INT;
        end else begin
            state_r <= state_nxt;
            op_a_r  <= op_a_nxt;
            lo_r    <= lo_nxt;
            hi_r    <= hi_nxt;
            mode_r  <= mode_nxt;
            fmt_r   <= fmt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // orderings against both thresholds

    logic a_lt_lo;
    logic a_eq_lo;
    logic un_lo;
    logic a_lt_hi;
    logic a_eq_hi;
    logic un_hi;

    wtc_order u_ord_lo (
        .val_x      (op_a_r),
        .val_y      (lo_r),
        .format_sel (fmt_r),
        .x_less     (a_lt_lo),
        .x_equal    (a_eq_lo),
        .unordered  (un_lo)
    );

    wtc_order u_ord_hi (
        .val_x      (op_a_r),
        .val_y      (hi_r),
        .format_sel (fmt_r),
        .x_less     (a_lt_hi),
        .x_equal    (a_eq_hi),
        .unordered  (un_hi)
    );

    ////////////////////////////////////////////////////////////////////////
    // condition select, registered in DECIDE

    logic cond_r;
    logic cond_nxt;
    logic unord_r;
    logic unord_nxt;
    logic a_gt_lo;
    logic a_gt_hi;
    logic any_un;

    always_comb begin
        any_un  = un_lo || (uses_upper(mode_r) && un_hi);
        // nan compares false except for not-equal
        a_gt_lo = !a_lt_lo && !a_eq_lo && !un_lo;
        a_gt_hi = !a_lt_hi && !a_eq_hi && !un_hi;
        cond_nxt  = cond_r;
        unord_nxt = unord_r;
        if (state_r == WTC_ST_DECIDE) begin
            unord_nxt = any_un;
            unique case (mode_r)
                WTC_MODE_EQ:  cond_nxt = a_eq_lo;
                WTC_MODE_GT:  cond_nxt = a_gt_lo;
                WTC_MODE_LT:  cond_nxt = a_lt_lo;
                WTC_MODE_GE:  cond_nxt = a_gt_lo || a_eq_lo;
                WTC_MODE_LE:  cond_nxt = a_lt_lo || a_eq_lo;
                WTC_MODE_NE:  cond_nxt = !a_eq_lo;
                // strict window, lower below upper assumed
                WTC_MODE_IN:  cond_nxt = a_gt_lo && a_lt_hi;
                WTC_MODE_OUT: cond_nxt = a_gt_hi || a_lt_lo;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cond_r  <= 1'b0;
            unord_r <= 1'b0;
        end else begin
            cond_r  <= cond_nxt;
            unord_r <= unord_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // published results

    logic res_r;
    logic res_nxt;
    logic fres_r;
    logic fres_nxt;
    logic sres_r;
    logic sres_nxt;
    logic upd_r;
    logic upd_nxt;
    logic useen_r;
    logic useen_nxt;

    always_comb begin
        res_nxt   = res_r;
        fres_nxt  = fres_r;
        sres_nxt  = sres_r;
        useen_nxt = useen_r;
        upd_nxt   = 1'b0;
        // enable dropped mid-scan: hold previous result
        if (state_r == WTC_ST_PUBLISH && compare_enable) begin
            res_nxt   = cond_r;
            upd_nxt   = 1'b1;
            useen_nxt = unord_r;
            if (fmt_r == WTC_FMT_FLOAT) begin
                fres_nxt = cond_r;
            end else begin
                sres_nxt = cond_r;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            res_r   <= `WTC_RESULT_RST;
            fres_r  <= `WTC_RESULT_RST;
            sres_r  <= `WTC_RESULT_RST;
            upd_r   <= 1'b0;
            useen_r <= 1'b0;
        end else begin
            res_r   <= res_nxt;
            fres_r  <= fres_nxt;
            sres_r  <= sres_nxt;
            upd_r   <= upd_nxt;
            useen_r <= useen_nxt;
        end
    end

    assign compare_result        = res_r;
    assign float_compare_result  = fres_r;
    assign signed_compare_result = sres_r;
    assign result_update         = upd_r;
    assign unordered_seen        = useen_r;

endmodule

// >>> wtc_top_assertions.sv
// port-level assertions of the wide threshold comparator
// assumes one core clock and an asynchronous active-low reset
`timescale 1ns/1ns

module wtc_top_assertions
    import wtc_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 nrst,
    input wire wtc_pkg::wtc_format_t format_sel,
    input wire logic                 compare_enable,
    input wire logic                 setting_wr,
    input wire logic                 setting_sel,
    input wire logic          [31:0] setting_data,
    input wire logic                 compare_result,
    input wire logic                 float_compare_result,
    input wire logic                 signed_compare_result,
    input wire logic                 result_update,
    input wire logic          [31:0] lower_threshold_setting,
    input wire logic          [31:0] upper_threshold_setting
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    sequence quiet_s;
        !result_update [*8];
    endsequence
    sequence publish_s;
        result_update ##1 quiet_s;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    result_hold_a:
    assert property (!result_update |-> $stable(compare_result))
        else $error("compare_result moved without a publish");
    publish_spacing_a:
    assert property (result_update |-> publish_s)
        else $error("publish pulses too close");
    enable_gate_a:
    assert property (result_update |-> $past(compare_enable))
        else $error("publish while enable low");
    float_tie_a:
    assert property (result_update && $past(format_sel, 3) == WTC_FMT_FLOAT
                     |-> float_compare_result == compare_result)
        else $error("float result differs from result");
    signed_tie_a:
    assert property (result_update && $past(format_sel, 3) == WTC_FMT_INT
                     |-> signed_compare_result == compare_result)
        else $error("signed result differs from result");
    float_keep_a:
    assert property (!(result_update && $past(format_sel, 3) == WTC_FMT_FLOAT)
                     |-> $stable(float_compare_result))
        else $error("float result moved on an integer scan");
    lower_write_a:
    assert property (setting_wr && !setting_sel |=> lower_threshold_setting == $past(setting_data))
        else $error("lower setting not written");
    upper_write_a:
    assert property (setting_wr && setting_sel |=> upper_threshold_setting == $past(setting_data))
        else $error("upper setting not written");
    setting_keep_a:
    assert property (!setting_wr |=> $stable(lower_threshold_setting)
                     && $stable(upper_threshold_setting))
        else $error("setting changed without a write");
endmodule

bind wtc_top wtc_top_assertions u_chk (.core_clk, .nrst, .format_sel, .compare_enable,
    .setting_wr, .setting_sel, .setting_data, .compare_result, .float_compare_result,
    .signed_compare_result, .result_update, .lower_threshold_setting,
    .upper_threshold_setting);

// >>> wtc_sink.sv
// consumer of the comparator result: counts publishes, keeps the last value
// assumes the comparator's clock and reset
`timescale 1ns/1ns

module wtc_sink (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        result_update,
    input  wire logic        compare_result,
    output logic      [15:0] pub_count,
    output logic             taken_result
);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pub_count <= 16'h0000;
            taken_result <= 1'b0;
        end else if (result_update) begin
            pub_count <= pub_count + 16'h0001;
            taken_result <= compare_result;
        end
    end
endmodule

// >>> wtc_top_tb.sv
// self-checking bench of the wide threshold comparator
// assumes the comparator top and the result sink model
`timescale 1ns/1ns

module wtc_top_tb;
    import wtc_pkg::*;
    localparam logic [31:0] IV [5] = '{32'hffff_fffa, 32'hffff_fffb, 32'h0000_0032,
                                       32'h0000_0064, 32'h0000_0065};
    localparam logic [31:0] FV [5] = '{32'hc000_0000, 32'hbf80_0000, 32'h0000_0000,
                                       32'h4020_0000, 32'h4040_0000};
    logic        core_clk, nrst, compare_enable, setting_wr, setting_sel;
    logic        lower_port_connected, upper_port_connected;
    logic        compare_result, float_compare_result, signed_compare_result;
    logic        result_update, unordered_seen, taken_result;
    logic [31:0] operand_a, lower_threshold, upper_threshold, setting_data;
    logic [31:0] lower_threshold_setting, upper_threshold_setting;
    logic [15:0] pub_count;
    wtc_format_t format_sel;
    wtc_mode_t   compare_mode;
    int          errors, cmp_count;

    wtc_top DUT (.core_clk, .nrst, .format_sel, .compare_mode, .compare_enable, .operand_a,
        .lower_threshold, .upper_threshold, .lower_port_connected, .upper_port_connected,
        .setting_wr, .setting_sel, .setting_data, .compare_result, .float_compare_result,
        .signed_compare_result, .result_update, .unordered_seen,
        .lower_threshold_setting, .upper_threshold_setting);
    wtc_sink u_sink (.core_clk, .nrst, .result_update, .compare_result, .pub_count,
        .taken_result);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded: a scan is 50 cycles, so 120 covers two
    task automatic wait_pub();
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (result_update !== 1'b1 && n < 120);
        if (result_update !== 1'b1) begin
            check("result_update", result_update, 32'h1);
            finish_test();
        end
    endtask

    // ordering key: signed ints and floats become unsigned-comparable, -0 folds to +0
    function automatic logic [31:0] key(input logic fl, input logic [31:0] x);
        if (!fl) return x ^ 32'h8000_0000;
        if (x[30:0] == 31'h0) return 32'h8000_0000;
        return x[31] ? ~x : {1'b1, x[30:0]};
    endfunction

    function automatic logic want(input logic fl, input logic [2:0] m,
                                  input logic [31:0] a, l, h);
        logic [31:0] ka, kl, kh;
        ka = key(fl, a);
        kl = key(fl, l);
        kh = key(fl, h);
        case (m)
            3'h0: return ka == kl;
            3'h1: return ka > kl;
            3'h2: return ka < kl;
            3'h3: return ka >= kl;
            3'h4: return ka <= kl;
            3'h5: return ka != kl;
            3'h6: return ka > kl && ka < kh;
            default: return ka > kh || ka < kl;
        endcase
    endfunction

    // inputs change right after a publish, so the next scan latches them
    task automatic eval(input logic fl, input logic [2:0] m, input logic [31:0] a, l, h,
                        input logic exp);
        @(posedge core_clk);
        format_sel <= wtc_format_t'(fl);
        compare_mode <= wtc_mode_t'(m);
        operand_a <= a;
        lower_threshold <= l;
        upper_threshold <= h;
        wait_pub();
        check("compare_result", compare_result, exp);
        if (fl) check("float_compare_result", float_compare_result, exp);
        else check("signed_compare_result", signed_compare_result, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        check("compare_result", compare_result, 32'h0);
        check("result_update", result_update, 32'h0);
        check("lower_setting", lower_threshold_setting, 32'h0);
        check("upper_setting", upper_threshold_setting, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_modes();
        logic [31:0] a, l, h;
        wait_pub();
        for (int f = 0; f < 2; f++) begin
            for (int m = 0; m < 8; m++) begin
                for (int i = 0; i < 5; i++) begin
                    a = f ? FV[i] : IV[i];
                    l = f ? FV[1] : IV[1];
                    h = (m >= 6) ? (f ? FV[3] : IV[3]) : a;
                    eval(f[0], m[2:0], a, l, h, want(f[0], m[2:0], a, l, h));
                end
            end
        end
        $display("test modes done");
    endtask

    task automatic t_nan();
        eval(1'b1, 3'h5, 32'h7fc0_0000, FV[1], FV[1], 1'b1);
        check("unordered_seen", unordered_seen, 32'h1);
        eval(1'b1, 3'h0, 32'h7fc0_0000, FV[1], FV[1], 1'b0);
        eval(1'b1, 3'h0, 32'h8000_0000, 32'h0, 32'h0, 1'b1);
        check("unordered_seen", unordered_seen, 32'h0);
        $display("test nan done");
    endtask

    task automatic t_hold();
        logic [15:0] n0;
        eval(1'b0, 3'h0, 32'h5, 32'h5, 32'h5, 1'b1);
        @(posedge core_clk);
        compare_enable <= 1'b0;
        operand_a <= 32'h6;
        // sink counts the last publish on this edge, so read the count after it
        @(negedge core_clk);
        n0 = pub_count;
        repeat (150) @(posedge core_clk);
        @(negedge core_clk);
        check("held compare_result", compare_result, 32'h1);
        check("sink result", taken_result, 32'h1);
        check("publish count", pub_count, n0);
        @(posedge core_clk);
        compare_enable <= 1'b1;
        wait_pub();
        check("compare_result", compare_result, 32'h0);
        $display("test hold done");
    endtask

    task automatic t_settings();
        @(posedge core_clk);
        setting_wr <= 1'b1;
        setting_sel <= 1'b0;
        setting_data <= 32'h0000_0010;
        @(posedge core_clk);
        setting_sel <= 1'b1;
        setting_data <= 32'h0000_0020;
        lower_port_connected <= 1'b0;
        upper_port_connected <= 1'b0;
        @(posedge core_clk);
        setting_wr <= 1'b0;
        @(negedge core_clk);
        check("lower_setting", lower_threshold_setting, 32'h10);
        check("upper_setting", upper_threshold_setting, 32'h20);
        wait_pub();
        eval(1'b0, 3'h6, 32'h18, 32'h30, 32'h40, 1'b1);
        eval(1'b0, 3'h7, 32'h21, 32'h0, 32'h40, 1'b1);
        $display("test settings done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        cmp_count = 0;
        nrst = 1'b0;
        format_sel = WTC_FMT_INT;
        compare_mode = WTC_MODE_EQ;
        compare_enable = 1'b1;
        operand_a = 32'h0;
        lower_threshold = 32'h0;
        upper_threshold = 32'h0;
        lower_port_connected = 1'b1;
        upper_port_connected = 1'b1;
        setting_wr = 1'b0;
        setting_sel = 1'b0;
        setting_data = 32'h0;
        t_reset();
        t_modes();
        t_nan();
        t_hold();
        t_settings();
        t_reset();
        finish_test();
    end
endmodule
